// ---- hdl/rwu_pkg.sv ----
// Operation
// R1: Free-running 48-bit time counter, 46 bits effective, on slow clock.
// R2: Clear the time counter to zero during power-on reset.
// R3: Time counter wraps from all ones to all zeros, never saturates.
// R4: Supply enable low during power-on reset, high once reset completes.
// R5: Any change of either alarm input drives supply enable high.
// R6: Any change of either alarm input captures the time counter.
// R7: Alarm event while system powered also raises an interrupt.
// R8: Each alarm input has its own programmable active polarity.
// R9: Two programmable wrap-around wake-up counters for periodic wake-up; only counter one drives supply enable high.
// R10: Wake-up counters tick once per slow clock cycle, 32-bit effective.
// R11: Second wake-up counter is 34 bits, otherwise like the first.
// R12: Aux output selectable as disabled or toggled by wake counter two.
// R13: Aux output may instead carry the slow crystal clock itself.
// R14: Clear wake counter two during power-on reset.
// R15: Battery-backed memory of 128 words by 32 bits.
// R16: Aux output polarity programmable.
// R17: Synchronise alarm inputs so one change gives one capture and wake.
package rwu_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int         ADR_W          = 12;
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_STATUS    = 12'h004;
  localparam logic [11:0] OFS_MASK      = 12'h008;
  localparam logic [11:0] OFS_TIME_LO   = 12'h00c;
  localparam logic [11:0] OFS_TIME_HI   = 12'h010;
  localparam logic [11:0] OFS_STAMP_LO  = 12'h014;
  localparam logic [11:0] OFS_STAMP_HI  = 12'h018;
  localparam logic [11:0] OFS_WK1_PER   = 12'h01c;
  localparam logic [11:0] OFS_WK2_PERLO = 12'h020;
  localparam logic [11:0] OFS_WK2_PERHI = 12'h024;
  localparam logic [11:0] OFS_WK1_CNT   = 12'h028;
  localparam logic [11:0] OFS_WK2_CNTLO = 12'h02c;
  localparam logic [11:0] OFS_WK2_CNTHI = 12'h030;
  localparam logic [11:0] OFS_RAM_BASE  = 12'h200;

  // ---------------------------------------------------------------
  // Sizes, field positions, reset values
  // ---------------------------------------------------------------
  localparam int TIME_W   = 48;
  localparam int WK1_W    = 32;
  localparam int WK2_W    = 34;
  localparam int RAM_WDS  = 128;
  localparam int RAM_AW   = 7;

  localparam int ST_ALARM_A = 0;
  localparam int ST_ALARM_B = 1;
  localparam int ST_WAKE1   = 2;
  localparam int ST_WAKE2   = 3;
  localparam int ST_W       = 4;

  localparam int CTL_SUPPLY_OFF = 7;

  localparam logic [31:0] WK1_PER_RST = 32'h0000_8000;
  localparam logic [33:0] WK2_PER_RST = 34'h0_0000_8000;

  typedef enum logic [1:0] {
    RWU_AUX_OFF,
    RWU_AUX_TOGGLE,
    RWU_AUX_SLOWCLK
  } rwu_aux_mode_t;

  // CTRL register layout, top bit first
  typedef struct packed {
    logic          wk2_en;
    logic          wk1_en;
    logic          aux_inv;
    rwu_aux_mode_t aux_mode;
    logic          pol_b;
    logic          pol_a;
  } rwu_ctrl_t;

  localparam int CTRL_W = 7;

endpackage

// ---- hdl/rwu_top.sv ----
// Our own choices: the Wishbone slave port and the register addresses.
module rwu_top
  import rwu_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               slow_clk_in,
  input  wire logic               wake_input_a,
  input  wire logic               wake_input_b,
  output logic                    supply_enable_out,
  output logic                    aux_periodic_out,
  output logic                    irq_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] apply_sel(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Level change between two samples of a synchronised input
  function automatic logic level_flip(input logic now_v,
                                      input logic prev_v);
    return now_v ^ prev_v;
  endfunction

  // Wake counters run 0..period, so expiry is at or past the period
  function automatic logic expired(input logic [WK2_W-1:0] cnt,
                                   input logic [WK2_W-1:0] per);
    return cnt >= per;
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] slow_sync_q;
  logic [1:0] a_sync_q;
  logic [1:0] b_sync_q;
  logic       slow_prev_q;
  logic       a_prev_q;
  logic       b_prev_q;

  // Slow clock kept apart: it never needs a reset, only two stages
  always_ff @(posedge mclk) begin
    slow_sync_q <= {slow_sync_q[0], slow_clk_in};
    slow_prev_q <= slow_sync_q[1];
  end

  always_ff @(posedge mclk) begin
    a_sync_q <= {a_sync_q[0], wake_input_a};  // R17
    b_sync_q <= {b_sync_q[0], wake_input_b};  // R17
  end

  // Prior samples only follow the synchronisers; a stale value left
  // over from reset is masked by rst_seen_q below.
  always_ff @(posedge mclk) begin
    a_prev_q <= a_sync_q[1];
    b_prev_q <= b_sync_q[1];
  end

  // ---------------------------------------------------------------
  // Change detection
  // ---------------------------------------------------------------
  logic tick;
  logic chg_a;
  logic chg_b;
  logic alarm_chg;
  logic rst_seen_q;

  // Alarm input edges are ignored in the first cycle after reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rst_seen_q <= 1'b0;
    end else begin
      rst_seen_q <= 1'b1;
    end
  end

  assign tick      = slow_sync_q[1] & ~slow_prev_q;
  assign chg_a     = rst_seen_q & level_flip(a_sync_q[1], a_prev_q);  // R17
  assign chg_b     = rst_seen_q & level_flip(b_sync_q[1], b_prev_q);  // R17
  assign alarm_chg = chg_a | chg_b;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic              req;
  logic              wr_now;
  logic              in_ram;
  logic [RAM_AW-1:0] ram_idx;

  assign req     = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where ack is seen by the master
  assign wr_now  = req & wb_we_i & wb_ack_o;
  assign in_ram  = (wb_adr_i >= OFS_RAM_BASE) &&
                   (wb_adr_i[ADR_W-1:9] == OFS_RAM_BASE[ADR_W-1:9]);
  assign ram_idx = wb_adr_i[RAM_AW+1:2];

  function automatic logic hit(input logic [ADR_W-1:0] ofs);
    return wr_now && (wb_adr_i[ADR_W-1:2] == ofs[ADR_W-1:2]);
  endfunction

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  rwu_ctrl_t   ctrl_q;
  logic [ST_W-1:0] mask_q;
  logic [31:0] wk1_per_q;
  logic [33:0] wk2_per_q;
  logic        supply_off_req;
  logic [31:0] ctrl_wr;

  assign ctrl_wr = apply_sel({25'h0, ctrl_q}, wb_dat_i, wb_sel_i);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_q <= '0;
    end else if (hit(OFS_CTRL)) begin
      ctrl_q <= rwu_ctrl_t'(ctrl_wr[CTRL_W-1:0]);  // R8 R16
    end
  end

  // Power-down is a write-only pulse; it is never stored
  assign supply_off_req = hit(OFS_CTRL) & wb_sel_i[0] &
                          wb_dat_i[CTL_SUPPLY_OFF];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mask_q <= '0;
    end else if (hit(OFS_MASK) && wb_sel_i[0]) begin
      mask_q <= wb_dat_i[ST_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wk1_per_q <= WK1_PER_RST;
    end else if (hit(OFS_WK1_PER)) begin
      wk1_per_q <= apply_sel(wk1_per_q, wb_dat_i, wb_sel_i);  // R9
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wk2_per_q <= WK2_PER_RST;
    end else begin
      if (hit(OFS_WK2_PERLO)) begin
        wk2_per_q[31:0] <= apply_sel(wk2_per_q[31:0], wb_dat_i,
                                     wb_sel_i);
      end
      if (hit(OFS_WK2_PERHI) && wb_sel_i[0]) begin
        wk2_per_q[33:32] <= wb_dat_i[1:0];  // R11
      end
    end
  end

  // ---------------------------------------------------------------
  // Real time counter and timestamp
  // ---------------------------------------------------------------
  logic [TIME_W-1:0] time_q;
  logic [TIME_W-1:0] stamp_q;

  // Full 48-bit width kept; upper two bits are never of use in practice
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      time_q <= '0;  // R2
    end else if (tick) begin
      time_q <= time_q + 48'h1;  // R1 R3
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stamp_q <= '0;
    end else if (alarm_chg) begin
      stamp_q <= time_q;  // R6
    end
  end

  // ---------------------------------------------------------------
  // Wake-up counters
  // ---------------------------------------------------------------
  logic [WK1_W-1:0] wk1_cnt_q;
  logic [WK2_W-1:0] wk2_cnt_q;
  logic             wk1_hit;
  logic             wk2_hit;

  assign wk1_hit = tick & ctrl_q.wk1_en &
                   expired({2'b00, wk1_cnt_q}, {2'b00, wk1_per_q});
  assign wk2_hit = tick & ctrl_q.wk2_en & expired(wk2_cnt_q, wk2_per_q);

  // Disabling a counter restarts it from zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wk1_cnt_q <= '0;
    end else if (!ctrl_q.wk1_en) begin
      wk1_cnt_q <= '0;
    end else if (wk1_hit) begin
      wk1_cnt_q <= '0;  // R9
    end else if (tick) begin
      wk1_cnt_q <= wk1_cnt_q + 32'h1;  // R10
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wk2_cnt_q <= '0;  // R14
    end else if (!ctrl_q.wk2_en) begin
      wk2_cnt_q <= '0;
    end else if (wk2_hit) begin
      wk2_cnt_q <= '0;  // R9 R11
    end else if (tick) begin
      wk2_cnt_q <= wk2_cnt_q + 34'h1;  // R10 R11
    end
  end

  // ---------------------------------------------------------------
  // Outputs to the outside world
  // ---------------------------------------------------------------
  logic aux_state_q;
  logic aux_raw;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aux_state_q <= 1'b0;
    end else if (wk2_hit) begin
      aux_state_q <= ~aux_state_q;  // R12
    end
  end

  always_comb begin
    case (ctrl_q.aux_mode)
      RWU_AUX_OFF:     aux_raw = 1'b0;  // R12
      RWU_AUX_TOGGLE:  aux_raw = aux_state_q;  // R12
      RWU_AUX_SLOWCLK: aux_raw = slow_sync_q[1];  // R13
      default:         aux_raw = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aux_periodic_out <= 1'b0;
    end else begin
      aux_periodic_out <= aux_raw ^ ctrl_q.aux_inv;  // R16
    end
  end

  // Wake events beat a software power-down in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      supply_enable_out <= 1'b0;  // R4
    end else if (!rst_seen_q || alarm_chg || wk1_hit) begin
      supply_enable_out <= 1'b1;  // R4 R5
    end else if (supply_off_req) begin
      supply_enable_out <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] clr;
  logic            lvl_a;
  logic            lvl_b;

  assign lvl_a = a_sync_q[1] ^ ctrl_q.pol_a;  // R8
  assign lvl_b = b_sync_q[1] ^ ctrl_q.pol_b;  // R8

  always_comb begin
    ev             = '0;
    ev[ST_ALARM_A] = chg_a & lvl_a & supply_enable_out;  // R7
    ev[ST_ALARM_B] = chg_b & lvl_b & supply_enable_out;  // R7
    ev[ST_WAKE1]   = wk1_hit;
    ev[ST_WAKE2]   = wk2_hit;
  end

  assign clr = (hit(OFS_STATUS) && wb_sel_i[0]) ?
               wb_dat_i[ST_W-1:0] : '0;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clr) | ev;  // R7
    end
  end

  // Registered, so irq trails the status bit by one cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_q & mask_q);  // R7
    end
  end

  // ---------------------------------------------------------------
  // Battery-backed memory, no reset so contents survive
  // ---------------------------------------------------------------
  logic [31:0] ram_q [RAM_WDS];

  always_ff @(posedge mclk) begin
    if (wr_now && in_ram) begin
      ram_q[ram_idx] <= apply_sel(ram_q[ram_idx], wb_dat_i,
                                  wb_sel_i);  // R15
    end
  end

  // ---------------------------------------------------------------
  // Read path and acknowledge
  // ---------------------------------------------------------------
  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h0;
    if (in_ram) begin
      rd_d = ram_q[ram_idx];
    end else begin
      case (wb_adr_i)
        OFS_CTRL:      rd_d = {25'h0, ctrl_q};
        OFS_STATUS:    rd_d = {28'h0, status_q};
        OFS_MASK:      rd_d = {28'h0, mask_q};
        OFS_TIME_LO:   rd_d = time_q[31:0];
        OFS_TIME_HI:   rd_d = {16'h0, time_q[47:32]};
        OFS_STAMP_LO:  rd_d = stamp_q[31:0];
        OFS_STAMP_HI:  rd_d = {16'h0, stamp_q[47:32]};
        OFS_WK1_PER:   rd_d = wk1_per_q;
        OFS_WK2_PERLO: rd_d = wk2_per_q[31:0];
        OFS_WK2_PERHI: rd_d = {30'h0, wk2_per_q[33:32]};
        OFS_WK1_CNT:   rd_d = wk1_cnt_q;
        OFS_WK2_CNTLO: rd_d = wk2_cnt_q[31:0];
        OFS_WK2_CNTHI: rd_d = {30'h0, wk2_cnt_q[33:32]};
        default:       rd_d = 32'h0;
      endcase
    end
  end

  // One wait state; unmapped addresses answer with zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  // Read data is taken at the request edge and stands until the next
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0;
    end else if (req && !wb_ack_o) begin
      wb_dat_o <= rd_d;
    end
  end

endmodule

// ---- bench/rwu_partner.sv ----
module rwu_partner (
  input  wire logic mclk,
  input  wire logic run,
  output logic      slow_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph;
  // Crystal halted between bursts so tick counts are exact
  initial begin
    slow_clk = 1'b0;
    ph = 0;
  end
  always @(posedge mclk) begin
    if (run) begin
      ph <= (ph == 7) ? 0 : ph + 1;
      if (ph == 7) slow_clk <= ~slow_clk;
    end
  end
endmodule

// ---- bench/rwu_checker.sv ----
module rwu_checker
  import rwu_pkg::*;
(
  input wire logic             mclk,
  input wire logic             sys_rst,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             slow_clk_in,
  input wire logic             wake_input_a,
  input wire logic             wake_input_b,
  input wire logic             supply_enable_out,
  input wire logic             aux_periodic_out,
  input wire logic             irq_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_ack_after_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("late ack");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_when_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_read_data_holds: assert property (
    !(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data moved");
  a_supply_low_reset: assert property (
    $fell(sys_rst) |-> !supply_enable_out) else $error("supply early");
  a_supply_rises: assert property (
    $fell(sys_rst) |-> ##[1:3] supply_enable_out) else $error("no supply");
  a_wake_a_supply: assert property (
    $changed(wake_input_a) |-> ##[1:6] supply_enable_out)
    else $error("input a no wake");
  a_wake_b_supply: assert property (
    $changed(wake_input_b) |-> ##[1:6] supply_enable_out)
    else $error("input b no wake");
endmodule
bind rwu_top rwu_checker rwu_checker_i (.mclk, .sys_rst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .slow_clk_in, .wake_input_a, .wake_input_b,
  .supply_enable_out, .aux_periodic_out, .irq_out);

// ---- bench/tb_top.sv ----
module tb_top
  import rwu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [11:0] wb_adr_i, a;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, d, e;
  logic        slow_clk_in, run, wake_input_a, wake_input_b;
  logic        supply_enable_out, aux_periodic_out, irq_out;
  int          mismatches, checks, seed, i;

  rwu_top rwu_top_i (.mclk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .slow_clk_in,
    .wake_input_a, .wake_input_b, .supply_enable_out, .aux_periodic_out,
    .irq_out);
  rwu_partner rwu_partner_i (.mclk, .run, .slow_clk(slow_clk_in));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic end_of_test();
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask
  task automatic chk_pin(input logic ex, input logic got);
    checks++;
    if (got !== ex) begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask
  task automatic bus(input logic we, input logic [11:0] ad,
                     input logic [31:0] dw, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= ad;
    wb_dat_i <= dw;
    wb_sel_i <= s;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      mismatches++;
      end_of_test();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] dw);
    bus(1'b1, ad, dw, 4'hf);
    repeat (3) @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] ex);
    bus(1'b0, ad, 32'h0, 4'hf);
    chk(ex, q);
  endtask
  task automatic slow_to(input logic l);
    if (slow_clk_in !== l) begin
      run <= 1'b1;
      while (slow_clk_in !== l) @(posedge mclk);
      run <= 1'b0;
    end
    repeat (8) @(posedge mclk);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      slow_to(1'b0);
      slow_to(1'b1);
    end
  endtask
  task automatic pins(input logic va, input logic vb);
    wake_input_a <= va;
    wake_input_b <= vb;
    repeat (10) @(posedge mclk);
  endtask
  function automatic logic [31:0] ctl(input logic pb, input rwu_aux_mode_t m,
                                      input logic inv);
    rwu_ctrl_t c;
    c = '{wk2_en: 1'b1, wk1_en: 1'b1, aux_inv: inv, aux_mode: m,
          pol_b: pb, pol_a: 1'b0};
    return {25'h0, c};
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, n,
                                        input logic [3:0] s);
    for (int k = 0; k < 4; k++) if (s[k]) o[8*k +: 8] = n[8*k +: 8];
    return o;
  endfunction
  function automatic logic aux_exp(input int t, input int per);
    return 1'((t / (per + 1)) % 2);
  endfunction

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    end_of_test();
  end
  initial begin
    mismatches = 0;
    checks = 0;
    seed = 20;
    {wb_cyc_i, wb_stb_i, wb_we_i, run, wake_input_a, wake_input_b} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    sys_rst = 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk_pin(1'b1, supply_enable_out);
    rd(OFS_TIME_LO, 32'h0);
    rd(OFS_TIME_HI, 32'h0);
    rd(OFS_WK2_CNTLO, 32'h0);
    rd(12'h100, 32'h0);
    for (i = 0; i < 4; i++) begin
      a = OFS_RAM_BASE + {3'h0, 7'($random(seed)), 2'h0};
      d = $random(seed);
      e = $random(seed);
      wr(a, d);
      bus(1'b1, a, e, 4'h5);
      rd(a, merge(d, e, 4'h5));
    end
    wr(OFS_WK1_PER, 32'h5);
    wr(OFS_WK2_PERLO, 32'h3);
    wr(OFS_WK2_PERHI, 32'h0);
    wr(OFS_MASK, 32'h3);
    wr(OFS_CTRL, ctl(1'b1, RWU_AUX_TOGGLE, 1'b0));
    tick(4);
    rd(OFS_TIME_LO, 32'h4);
    rd(OFS_WK1_CNT, 32'h4);
    rd(OFS_WK2_CNTLO, 32'h0);
    chk_pin(aux_exp(4, 3), aux_periodic_out);
    tick(2);
    rd(OFS_WK1_CNT, 32'h0);
    rd(OFS_STATUS, 32'hc);
    chk_pin(1'b0, irq_out);
    wr(OFS_STATUS, 32'hc);
    pins(1'b1, 1'b0);
    rd(OFS_STAMP_LO, 32'h6);
    rd(OFS_STATUS, 32'h1);
    chk_pin(1'b1, irq_out);
    wr(OFS_STATUS, 32'h1);
    tick(1);
    pins(1'b1, 1'b1);
    rd(OFS_STAMP_LO, 32'h7);
    rd(OFS_STATUS, 32'h0);
    pins(1'b1, 1'b0);
    rd(OFS_STATUS, 32'h2);
    chk_pin(1'b1, irq_out);
    wr(OFS_MASK, 32'h0);
    chk_pin(1'b0, irq_out);
    wr(OFS_CTRL, ctl(1'b1, RWU_AUX_TOGGLE, 1'b0) | 32'h80);
    chk_pin(1'b0, supply_enable_out);
    tick(1);
    pins(1'b0, 1'b0);
    chk_pin(1'b1, supply_enable_out);
    rd(OFS_STAMP_LO, 32'h8);
    wr(OFS_CTRL, ctl(1'b1, RWU_AUX_TOGGLE, 1'b0) | 32'h80);
    chk_pin(1'b0, supply_enable_out);
    pins(1'b1, 1'b0);
    chk_pin(1'b1, supply_enable_out);
    rd(OFS_STATUS, 32'ha);
    wr(OFS_CTRL, ctl(1'b1, RWU_AUX_SLOWCLK, 1'b0));
    slow_to(1'b0);
    chk_pin(1'b0, aux_periodic_out);
    slow_to(1'b1);
    chk_pin(1'b1, aux_periodic_out);
    wr(OFS_CTRL, ctl(1'b1, RWU_AUX_SLOWCLK, 1'b1));
    chk_pin(1'b0, aux_periodic_out);
    wr(OFS_CTRL, ctl(1'b1, RWU_AUX_OFF, 1'b0));
    chk_pin(1'b0, aux_periodic_out);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    chk_pin(1'b0, supply_enable_out);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk_pin(1'b1, supply_enable_out);
    rd(OFS_TIME_LO, 32'h0);
    rd(OFS_WK2_CNTLO, 32'h0);
    rd(a, merge(d, e, 4'h5));
    end_of_test();
  end
endmodule
